//--- logic/tqm_pkg.sv
// Constants, field positions and carrier types of the transmit queue manager.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package tqm_pkg;
  // Register offsets on the host register port
  localparam logic [7:0] TQM_OFS_TX_CONTROL = 8'h70;
  localparam logic [7:0] TQM_OFS_TX_STATUS = 8'h72;
  localparam logic [7:0] TQM_OFS_TX_FREE = 8'h78;
  localparam logic [7:0] TQM_OFS_TX_QCMD = 8'h80;
  localparam logic [7:0] TQM_OFS_RX_QCMD = 8'h82;
  localparam logic [7:0] TQM_OFS_TX_PTR = 8'h84;
  localparam logic [7:0] TQM_OFS_RX_PTR = 8'h86;
  localparam logic [7:0] TQM_OFS_IRQ_EN = 8'h90;
  localparam logic [7:0] TQM_OFS_IRQ_STAT = 8'h92;
  localparam logic [7:0] TQM_OFS_SPACE_REQ = 8'h9E;
  localparam logic [7:0] TQM_OFS_DATA = 8'hC0;
  // Field positions
  localparam int TQM_TXC_ENABLE = 0;
  localparam int TQM_QC_MANUAL = 0;
  localparam int TQM_QC_SPACE = 1;
  localparam int TQM_QC_AUTO = 2;
  localparam int TQM_RXQ_DMA = 3;
  localparam int TQM_RXP_BIG = 11;
  localparam int TQM_PTR_AUTO = 14;
  localparam int TQM_IRQ_DONE = 14;
  localparam int TQM_IRQ_SPACE = 6;
  localparam int TQM_CW_IRQ = 15;
  // Sizes and reset values
  localparam logic [12:0] TQM_MEM_BYTES = 13'h1800;
  localparam logic [11:0] TQM_MEM_WORDS = 12'hC00;
  localparam logic [10:0] TQM_MAX_FRAME = 11'h7D0;
  localparam logic [15:0] TQM_RST_REG = 16'h0000;
  localparam logic [8:0] TQM_TXC_MASK = 9'h1EF;
  // One word towards the MAC
  typedef struct packed {
    logic [15:0] data;
    logic last;
    logic odd;
  } tqm_word_t;
  // Reader states
  typedef enum logic [2:0] {
    TQM_S_IDLE = 3'b000,
    TQM_S_HDR0 = 3'b001,
    TQM_S_HDR1 = 3'b010,
    TQM_S_DATA = 3'b011,
    TQM_S_DONE = 3'b100
  } tqm_state_t;
endpackage

//--- logic/tqm_transmit_queue.sv
// Transmit queue manager: packet memory, enqueue control, status and MAC stream.
// Assumes the host register port is synchronous to clk and the MAC side
// takes words on valid and ready; the endian strap is an asynchronous pin.
module tqm_transmit_queue (
  input wire logic clk,
  input wire logic reset,
  input wire logic endian_strap,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic irq_n,
  output tqm_pkg::tqm_word_t mac_word,
  output logic mac_valid,
  input wire logic mac_ready,
  output logic [8:0] mac_ctrl
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage and state
  logic [15:0] mem [0:3071]; // Packet memory, one 16-bit word per entry
  logic [2:0] strap_sync_ff; // Pin synchroniser, three stages
  logic strap_ff; // Filtered strap level
  logic [8:0] tx_control_ff; // Transmit control bits as the MAC sees them
  logic [15:0] rx_qcmd_ff, rx_ptr_ff, irq_en_ff, irq_stat_ff, space_req_ff; // Host registers
  logic [10:0] ptr_ff; // Byte offset inside the frame being prepared
  logic ptr_auto_ff, auto_ff; // Pointer step and auto enqueue modes
  logic manual_ff; // Manual enqueue in flight
  logic space_arm_ff; // Space request armed
  logic [11:0] tail_ff; // Word index where the next frame is prepared
  logic [11:0] head_ff; // Word index of the oldest queued frame
  logic [12:0] free_ff; // Free bytes in the ring
  logic [10:0] prep_len_ff; // Length latched from the prepared header
  logic prep_valid_ff, cur_irq_ff; // Header seen; done interrupt wanted
  logic [11:0] queued_ff; // Frames committed but not yet sent
  tqm_pkg::tqm_state_t state_ff;
  logic [11:0] rd_addr_ff;
  logic [5:0] cur_tag_ff;
  logic [10:0] cur_len_ff, words_left_ff; // Frame length and words still to push
  tqm_pkg::tqm_word_t slot0_ff; // Buffer head, drives the MAC directly
  tqm_pkg::tqm_word_t slot1_ff;
  logic valid0_ff, valid1_ff; // Buffer slot occupancy
  logic [15:0] reg_rdata_ff;
  logic irq_n_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Address decode and host strobes
  wire logic wr_ctl = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_TX_CONTROL);
  wire logic wr_qcmd = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_TX_QCMD);
  wire logic wr_rxq = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_RX_QCMD);
  wire logic wr_ptr = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_TX_PTR);
  wire logic wr_rxp = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_RX_PTR);
  wire logic wr_ien = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_IRQ_EN);
  wire logic wr_ist = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_IRQ_STAT);
  wire logic wr_req = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_SPACE_REQ);
  wire logic dma_on = rx_qcmd_ff[tqm_pkg::TQM_RXQ_DMA];
  // Data port is live only while the host has opened access
  wire logic data_wr = reg_wr && (reg_addr == tqm_pkg::TQM_OFS_DATA) && dma_on;
  wire logic data_rd = reg_rd && (reg_addr == tqm_pkg::TQM_OFS_DATA) && dma_on;
  wire logic big_endian = strap_ff | rx_ptr_ff[tqm_pkg::TQM_RXP_BIG];
  // Header words swap bytes in big-endian mode; payload never does
  wire logic [15:0] wdata_hdr = big_endian ? {reg_wdata[7:0], reg_wdata[15:8]} : reg_wdata;
  wire logic [15:0] rd_raw = mem[rd_addr_ff];
  wire logic [15:0] rd_hdr = big_endian ? {rd_raw[7:0], rd_raw[15:8]} : rd_raw;
  ////////////////////////////////////////////////////////////////////////////
  // Write address: frame base plus pointer, wrapped in the ring
  wire logic [12:0] wr_sum = {1'b0, tail_ff} + {3'h0, ptr_ff[10:1]};
  wire logic [12:0] wr_wrap = (wr_sum >= {1'b0, tqm_pkg::TQM_MEM_WORDS}) ?
    wr_sum - {1'b0, tqm_pkg::TQM_MEM_WORDS} : wr_sum;
  wire logic [11:0] wr_addr = wr_wrap[11:0];
  // Pointer moves by one word on each data access when enabled
  wire logic ptr_step = ptr_auto_ff && (data_wr || data_rd);
  // Header word at byte offset 2 carries the length
  wire logic len_write = data_wr && (ptr_ff[10:1] == 10'h001);
  ////////////////////////////////////////////////////////////////////////////
  // Enqueue decisions
  // Frames occupy whole double words: header plus payload rounded up
  wire logic [11:0] prep_dw = 12'((13'(prep_len_ff) + 13'h007) >> 2);
  wire logic [12:0] prep_bytes = {prep_dw[10:0], 2'b00};
  wire logic [11:0] prep_words = {prep_dw[10:0], 1'b0};
  wire logic manual_go = wr_qcmd && reg_wdata[tqm_pkg::TQM_QC_MANUAL] && !manual_ff
    && prep_valid_ff;
  // Auto mode commits when the host closes the data access window
  wire logic dma_close = wr_rxq && dma_on && !reg_wdata[tqm_pkg::TQM_RXQ_DMA];
  wire logic auto_go = auto_ff && dma_close && prep_valid_ff;
  wire logic commit = manual_go || auto_go;
  wire logic [12:0] tail_sum = {1'b0, tail_ff} + {1'b0, prep_words};
  wire logic [11:0] tail_next = (tail_sum >= {1'b0, tqm_pkg::TQM_MEM_WORDS}) ?
    12'(tail_sum - {1'b0, tqm_pkg::TQM_MEM_WORDS}) : tail_sum[11:0];
  ////////////////////////////////////////////////////////////////////////////
  // Reader and buffer handshakes
  wire logic [11:0] cur_dw = 12'((13'(cur_len_ff) + 13'h007) >> 2);
  wire logic [12:0] cur_bytes = {cur_dw[10:0], 2'b00};
  wire logic [12:0] head_sum = {1'b0, head_ff} + {1'b0, cur_dw[10:0], 1'b0};
  wire logic [11:0] head_next = (head_sum >= {1'b0, tqm_pkg::TQM_MEM_WORDS}) ?
    12'(head_sum - {1'b0, tqm_pkg::TQM_MEM_WORDS}) : head_sum[11:0];
  wire logic [11:0] rd_inc = (rd_addr_ff == tqm_pkg::TQM_MEM_WORDS - 12'h001) ?
    12'h000 : rd_addr_ff + 12'h001;
  wire logic push_ready = !valid1_ff;
  wire logic push = (state_ff == tqm_pkg::TQM_S_DATA) && push_ready;
  wire logic pop = valid0_ff && mac_ready;
  // Done only once the last word has left the buffer
  wire logic done = (state_ff == tqm_pkg::TQM_S_DONE) && !valid0_ff;
  wire logic start = (state_ff == tqm_pkg::TQM_S_IDLE) && (queued_ff != 12'h000)
    && tx_control_ff[tqm_pkg::TQM_TXC_ENABLE];
  // Payload passes as written: addresses and type field untouched
  wire tqm_pkg::tqm_word_t push_word = {rd_raw, words_left_ff == 11'h001,
    (words_left_ff == 11'h001) && cur_len_ff[0]};
  ////////////////////////////////////////////////////////////////////////////
  // Space and interrupt events
  wire logic [17:0] req_bytes = {space_req_ff, 2'b00};
  wire logic space_hit = space_arm_ff && ({5'h00, free_ff} >= req_bytes);
  wire logic [15:0] irq_set = ({15'h0000, done && cur_irq_ff} << tqm_pkg::TQM_IRQ_DONE)
    | ({15'h0000, space_hit} << tqm_pkg::TQM_IRQ_SPACE);
  wire logic [15:0] irq_clr = wr_ist ? reg_wdata : 16'h0000;
  // Set wins over a clear in the same cycle
  wire logic [15:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  wire logic [15:0] irq_gate = irq_stat_ff & irq_en_ff
    & ((16'h0001 << tqm_pkg::TQM_IRQ_DONE) | (16'h0001 << tqm_pkg::TQM_IRQ_SPACE));
  wire logic [12:0] nxt_free = free_ff - (commit ? prep_bytes : 13'h0000)
    + (done ? cur_bytes : 13'h0000);
  wire logic [11:0] nxt_queued = queued_ff + (commit ? 12'h001 : 12'h000)
    - (done ? 12'h001 : 12'h000);
  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  logic [15:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 16'h0000; // Unmapped and data reads return zero
    if (reg_addr == tqm_pkg::TQM_OFS_TX_CONTROL)
      nxt_rdata = {7'h00, tx_control_ff};
    else if (reg_addr == tqm_pkg::TQM_OFS_TX_STATUS)
      nxt_rdata = {10'h000, cur_tag_ff};
    else if (reg_addr == tqm_pkg::TQM_OFS_TX_FREE)
      nxt_rdata = {3'h0, free_ff};
    else if (reg_addr == tqm_pkg::TQM_OFS_TX_QCMD)
      nxt_rdata = {13'h0000, auto_ff, space_arm_ff, manual_ff};
    else if (reg_addr == tqm_pkg::TQM_OFS_RX_QCMD)
      nxt_rdata = rx_qcmd_ff;
    else if (reg_addr == tqm_pkg::TQM_OFS_TX_PTR)
      nxt_rdata = {1'b0, ptr_auto_ff, 3'h0, ptr_ff};
    else if (reg_addr == tqm_pkg::TQM_OFS_RX_PTR)
      nxt_rdata = rx_ptr_ff;
    else if (reg_addr == tqm_pkg::TQM_OFS_IRQ_EN)
      nxt_rdata = irq_en_ff;
    else if (reg_addr == tqm_pkg::TQM_OFS_IRQ_STAT)
      nxt_rdata = irq_stat_ff;
    else if (reg_addr == tqm_pkg::TQM_OFS_SPACE_REQ)
      nxt_rdata = space_req_ff;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (reset)
      strap_sync_ff <= 3'h0;
    else
      strap_sync_ff <= {strap_sync_ff[1:0], endian_strap};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      strap_ff <= 1'b0;
    else if (strap_sync_ff[1] == strap_sync_ff[2])
      strap_ff <= strap_sync_ff[2];
  end
  ////////////////////////////////////////////////////////////////////////////
  // Packet memory write port; no reset, contents are don't-care
  always_ff @(posedge clk)
  begin
    if (data_wr)
      mem[wr_addr] <= reg_wdata;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_control_ff <= 9'h000;
      rx_qcmd_ff <= tqm_pkg::TQM_RST_REG;
      rx_ptr_ff <= tqm_pkg::TQM_RST_REG;
      irq_en_ff <= tqm_pkg::TQM_RST_REG;
      space_req_ff <= tqm_pkg::TQM_RST_REG;
      auto_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        tx_control_ff <= reg_wdata[8:0] & tqm_pkg::TQM_TXC_MASK;
      if (wr_rxq)
        rx_qcmd_ff <= reg_wdata;
      if (wr_rxp)
        rx_ptr_ff <= reg_wdata;
      if (wr_ien)
        irq_en_ff <= reg_wdata;
      if (wr_req)
        space_req_ff <= reg_wdata;
      if (wr_qcmd)
        auto_ff <= reg_wdata[tqm_pkg::TQM_QC_AUTO];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Data pointer; a commit rewinds it for the next frame
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ptr_ff <= 11'h000;
      ptr_auto_ff <= 1'b0;
    end
    else if (wr_ptr)
    begin
      ptr_ff <= {reg_wdata[10:1], 1'b0};
      ptr_auto_ff <= reg_wdata[tqm_pkg::TQM_PTR_AUTO];
    end
    else if (commit)
      ptr_ff <= 11'h000;
    else if (ptr_step)
      ptr_ff <= ptr_ff + 11'h002;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Frame preparation and enqueue bookkeeping
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prep_len_ff <= 11'h000;
      prep_valid_ff <= 1'b0;
      tail_ff <= 12'h000;
      queued_ff <= 12'h000;
      free_ff <= tqm_pkg::TQM_MEM_BYTES;
      manual_ff <= 1'b0;
      space_arm_ff <= 1'b0;
    end
    else
    begin
      // Prepared lengths beyond the largest frame are clipped; the reader still takes the stored length
      if (len_write)
        prep_len_ff <= (wdata_hdr[10:0] > tqm_pkg::TQM_MAX_FRAME) ?
          tqm_pkg::TQM_MAX_FRAME : wdata_hdr[10:0];
      if (len_write)
        prep_valid_ff <= 1'b1;
      else if (commit)
        prep_valid_ff <= 1'b0;
      if (commit)
        tail_ff <= tail_next;
      queued_ff <= nxt_queued;
      free_ff <= nxt_free;
      // Manual bit drops when the queue drains after a send
      manual_ff <= manual_go || (manual_ff && !(done && queued_ff == 12'h001));
      space_arm_ff <= (wr_qcmd && reg_wdata[tqm_pkg::TQM_QC_SPACE])
        || (space_arm_ff && !space_hit);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Reader: header, payload into the buffer, then release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= tqm_pkg::TQM_S_IDLE;
      rd_addr_ff <= 12'h000;
      head_ff <= 12'h000;
      cur_tag_ff <= 6'h00;
      cur_irq_ff <= 1'b0;
      cur_len_ff <= 11'h000;
      words_left_ff <= 11'h000;
    end
    else
    begin
      case (state_ff)
        tqm_pkg::TQM_S_IDLE:
        begin
          if (start)
          begin
            rd_addr_ff <= head_ff;
            state_ff <= tqm_pkg::TQM_S_HDR0;
          end
        end
        tqm_pkg::TQM_S_HDR0:
        begin
          cur_tag_ff <= rd_hdr[5:0];
          cur_irq_ff <= rd_hdr[tqm_pkg::TQM_CW_IRQ];
          rd_addr_ff <= rd_inc;
          state_ff <= tqm_pkg::TQM_S_HDR1;
        end
        tqm_pkg::TQM_S_HDR1:
        begin
          cur_len_ff <= rd_hdr[10:0];
          words_left_ff <= 11'((12'(rd_hdr[10:0]) + 12'h001) >> 1);
          rd_addr_ff <= rd_inc;
          state_ff <= (rd_hdr[10:0] == 11'h000) ? tqm_pkg::TQM_S_DONE : tqm_pkg::TQM_S_DATA;
        end
        tqm_pkg::TQM_S_DATA:
        begin
          if (push)
          begin
            rd_addr_ff <= rd_inc;
            words_left_ff <= words_left_ff - 11'h001;
            if (words_left_ff == 11'h001)
              state_ff <= tqm_pkg::TQM_S_DONE;
          end
        end
        tqm_pkg::TQM_S_DONE:
        begin
          if (done)
          begin
            head_ff <= head_next;
            state_ff <= tqm_pkg::TQM_S_IDLE;
          end
        end
        default:
          state_ff <= tqm_pkg::TQM_S_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; slot0 faces the MAC so a stall loses nothing
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      valid0_ff <= 1'b0;
      valid1_ff <= 1'b0;
      slot0_ff <= '0;
      slot1_ff <= '0;
    end
    else if (pop)
    begin
      valid0_ff <= valid1_ff || push;
      slot0_ff <= valid1_ff ? slot1_ff : push_word;
      valid1_ff <= 1'b0;
    end
    else if (push && valid0_ff)
    begin
      slot1_ff <= push_word;
      valid1_ff <= 1'b1;
    end
    else if (push)
    begin
      slot0_ff <= push_word;
      valid0_ff <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Status and output registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_stat_ff <= tqm_pkg::TQM_RST_REG;
      reg_rdata_ff <= 16'h0000;
      irq_n_ff <= 1'b1;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      reg_rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
      irq_n_ff <= ~|irq_gate;
    end
  end

  // MAC uses the CRC and pad enables to decide trailer handling
  assign mac_ctrl = tx_control_ff;
  assign mac_word = slot0_ff;
  assign mac_valid = valid0_ff;
  assign reg_rdata = reg_rdata_ff;
  assign irq_n = irq_n_ff;

endmodule // tqm_transmit_queue

//--- tb/tqm_assertions.sv
// Port checks for the transmit queue manager.
// Assumes one clock and the synchronous active-high reset.
module tqm_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic endian_strap,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic irq_n,
  input wire tqm_pkg::tqm_word_t mac_word,
  input wire logic mac_valid,
  input wire logic mac_ready,
  input wire logic [8:0] mac_ctrl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] en_ff; // Shadow of the interrupt enables
  logic [8:0] txc_ff; // Shadow of the control bits the MAC sees
  // Shadows follow host writes, so checks need no hierarchy peeking
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      en_ff <= 16'h0000;
      txc_ff <= 9'h000;
    end
    else if (reg_wr && reg_addr == tqm_pkg::TQM_OFS_IRQ_EN)
      en_ff <= reg_wdata;
    else if (reg_wr && reg_addr == tqm_pkg::TQM_OFS_TX_CONTROL)
      txc_ff <= reg_wdata[8:0] & tqm_pkg::TQM_TXC_MASK;
  end
  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  free_width_a: assert property ($past(reg_rd)
    && $past(reg_addr) == tqm_pkg::TQM_OFS_TX_FREE
    |-> reg_rdata[15:13] == 3'h0 && reg_rdata[12:0] <= tqm_pkg::TQM_MEM_BYTES)
    else $error("free memory beyond 13 bit byte count");
  data_read_a: assert property ($past(reg_rd) && $past(reg_addr) == tqm_pkg::TQM_OFS_DATA
    |-> reg_rdata == 16'h0000)
    else $error("data port read not zero");
  irq_gate_a: assert property (!irq_n |-> ($past(en_ff) & 16'h4040) != 16'h0000)
    else $error("interrupt without an enable");
  // A frame end in the clear cycle may raise the line again, so skip those
  irq_clear_a: assert property (reg_wr && reg_addr == tqm_pkg::TQM_OFS_IRQ_STAT
    && reg_wdata == 16'hFFFF && !mac_valid && !$past(mac_valid) && !$past(mac_valid, 2)
    && !$past(reg_wr) |-> ##2 irq_n)
    else $error("interrupt stays after clear all");
  valid_hold_a: assert property (mac_valid && !mac_ready
    |=> mac_valid && $stable(mac_word))
    else $error("stalled word dropped or changed");
  ctrl_mirror_a: assert property (reg_wr && reg_addr == tqm_pkg::TQM_OFS_TX_CONTROL
    |-> ##[1:2] mac_ctrl == txc_ff)
    else $error("control copy wrong");
  odd_last_a: assert property (mac_valid && mac_word.odd |-> mac_word.last)
    else $error("odd byte not on final word");
  frame_end_c: cover property (mac_valid && mac_ready && mac_word.last);
  stall_c: cover property (mac_valid && !mac_ready);
  irq_c: cover property ($fell(irq_n));
endmodule // tqm_checker

bind tqm_transmit_queue tqm_checker i_tqm_checker (.clk(clk), .reset(reset),
  .endian_strap(endian_strap), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n(irq_n), .mac_word(mac_word),
  .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_ctrl(mac_ctrl));

//--- tb/tqm_mac_model.sv
// Behavioural MAC sink for the transmit stream.
// Assumes the bench steers stall and slow and judges the words itself.
module tqm_mac_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic slow,
  output logic mac_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ready_ff; // Ready level, moved off the sampling edge
  // Slow mode is ready every second cycle; stall holds the queue up
  always @(negedge clk)
  begin
    if (reset || stall)
      ready_ff <= 1'b0;
    else
      ready_ff <= slow ? ~ready_ff : 1'b1;
  end
  assign mac_ready = ready_ff;
endmodule // tqm_mac_model

//--- tb/tb_tqm_transmit_queue.sv
// Self-checking bench for the transmit queue manager.
// Assumes the checker binds itself and the MAC model sinks the stream.
module tb_tqm_transmit_queue;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic endian_strap = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic irq_n;
  tqm_pkg::tqm_word_t mac_word;
  logic mac_valid;
  logic mac_ready;
  logic [8:0] mac_ctrl;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [17:0] rx_q[$]; // Words taken by the MAC, in order
  int failures = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  tqm_transmit_queue i_tqm_transmit_queue (.clk(clk), .reset(reset),
    .endian_strap(endian_strap), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n(irq_n), .mac_word(mac_word),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_ctrl(mac_ctrl));
  tqm_mac_model i_tqm_mac_model (.clk(clk), .reset(reset), .stall(stall), .slow(slow),
    .mac_ready(mac_ready));
  // Record each handshake
  always @(posedge clk)
  begin
    if (mac_valid && mac_ready)
      rx_q.push_back(mac_word);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Counts: %0d failures, %0d comparisons", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Read data stands the cycle after the strobe edge
  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check16(reg_rdata, exp, "register");
  endtask
  // Pointer auto step, start access, header words, then payload
  task automatic load(input logic [15:0] cw, input logic [15:0] lw, input logic [15:0] b,
    input int n);
    wr(8'h84, 16'h4000);
    wr(8'h82, 16'h0008);
    wr(8'hC0, cw);
    wr(8'hC0, lw);
    for (int i = 0; i < n; i++)
      wr(8'hC0, b + 16'(i));
  endtask
  // Odd frames only carry the low byte of their final word
  task automatic check_frame(input logic [15:0] b, input int len);
    int n;
    logic [17:0] w;
    logic [15:0] m;
    n = (len + 1) / 2;
    for (int k = 0; k < 400 && rx_q.size() < n; k++)
      @(negedge clk);
    check16(16'(rx_q.size() >= n), 16'h0001, "word count");
    for (int i = 0; i < n && rx_q.size() > 0; i++)
    begin
      w = rx_q.pop_front();
      m = (i == n - 1 && len % 2 == 1) ? 16'h00FF : 16'hFFFF;
      check16(w[17:2] & m, (b + 16'(i)) & m, "payload");
      check16({14'h0, w[1:0]}, {14'h0, i == n - 1, i == n - 1 && len % 2 == 1}, "flags");
    end
  endtask
  task automatic wait_free();
    for (int k = 0; k < 100 && reg_rdata !== 16'h1800; k++)
    begin
      @(negedge clk);
      reg_addr = 8'h78;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
    end
    check16(reg_rdata, 16'h1800, "space released");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [7:0] ofs[6] = '{8'h70, 8'h90, 8'h92, 8'h80, 8'h00, 8'hC0};
    for (int i = 0; i < 6; i++)
      rd_check(ofs[i], 16'h0000);
    rd_check(8'h78, 16'h1800);
  endtask
  task automatic test_manual();
    wr(8'h70, 16'h0006);
    rd_check(8'h70, 16'h0006);
    check16({7'h00, mac_ctrl}, 16'h0006, "mac control");
    wr(8'h90, 16'h4040);
    load(16'h8005, 16'h0005, 16'h1211, 3);
    wr(8'h80, 16'h0001);
    repeat (20) @(negedge clk);
    check16(16'(rx_q.size()), 16'h0000, "sent while off");
    rd_check(8'h78, 16'h17F4);
    slow = 1'b1;
    wr(8'h70, 16'h0007);
    check_frame(16'h1211, 5);
    wait_free();
    rd_check(8'h80, 16'h0000);
    rd_check(8'h72, 16'h0005);
    rd_check(8'h92, 16'h4000);
    check16({15'h0, irq_n}, 16'h0000, "irq low");
    wr(8'h92, 16'hFFFF);
    rd_check(8'h92, 16'h0000);
    check16({15'h0, irq_n}, 16'h0001, "irq high");
  endtask
  task automatic test_auto();
    wr(8'h70, 16'h0006);
    wr(8'h80, 16'h0004);
    load(16'h0001, 16'h0004, 16'h2100, 2);
    wr(8'h82, 16'h0000);
    load(16'h0002, 16'h0002, 16'h3100, 1);
    wr(8'h82, 16'h0000);
    rd_check(8'h78, 16'h17F0);
    stall = 1'b1;
    wr(8'h70, 16'h0001);
    repeat (30) @(negedge clk);
    stall = 1'b0;
    check_frame(16'h2100, 4);
    check_frame(16'h3100, 2);
    wait_free();
    rd_check(8'h72, 16'h0002);
    wr(8'h9E, 16'h0600);
    wr(8'h80, 16'h0006);
    rd_check(8'h92, 16'h0040);
    rd_check(8'h80, 16'h0004);
    check16({15'h0, irq_n}, 16'h0000, "space irq");
    wr(8'h92, 16'h0040);
    rd_check(8'h92, 16'h0000);
  endtask
  // Strap first, then the pointer bit with the strap low
  task automatic test_endian();
    wr(8'h80, 16'h0000);
    for (int m = 0; m < 2; m++)
    begin
      endian_strap = (m == 0);
      wr(8'h86, m == 1 ? 16'h0800 : 16'h0000);
      repeat (5) @(negedge clk);
      load(m == 0 ? 16'h0300 : 16'h0400, 16'h0400, 16'h4100, 2);
      wr(8'h80, 16'h0001);
      check_frame(16'h4100, 4);
      wait_free();
      rd_check(8'h80, 16'h0000);
      rd_check(8'h72, m == 0 ? 16'h0003 : 16'h0004);
    end
    wr(8'h86, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    test_reset();
    test_manual();
    test_auto();
    test_endian();
    complete_run();
  end
  // The tests need about 300 cycles; 20000 cycles means a hang
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end
endmodule // tb_tqm_transmit_queue
